// ==== rom_zone_pkg.sv ====
// Notes on behaviour
// [R1] Array splits into four 256-bit zones; any combination may become read-only.
// [R2] One nonvolatile lock bit per zone survives power cycles and resets.
// [R3] Lock bit 0 means writable (delivered state); 1 blocks all writes forever.
// [R4] Each lock bit may only go from 0 to 1, never back.
// [R5] Zones cover 00h-1Fh, 20h-3Fh, 40h-5Fh, 60h-7Fh; selectors 01h, 02h, 04h, 08h.
// [R6] Master queries status by dummy write with opcode 7h, then selector byte.
// [R7] Upper nibble of the selector byte is ignored; low nibble is decoded.
// [R8] Query acks address, selector, read address; returns 00h unlocked or FFh locked.
// [R9] Master locks a zone by start, opcode-7h write, selector, FFh, stop.
// [R10] Stop after acked FFh starts the timed write; any earlier stop aborts.
// [R11] No command is answered until a running protection write has finished.
// [R12] Master avoids pulling the line low during a write, else holds it low long.
// [R13] Opcode 1h write is a freeze request; acked unless already frozen.
// [R14] Freeze needs 55h then AAh; wrong byte is refused and nothing freezes.
// [R15] Freeze write starts only on stop after acked AAh; other stops abort.
// [R16] Once frozen, no lock bit can ever change again.
// [R17] Stop is an idle high frame; master leaves the line high during freeze write.
// [R18] Array write acks address and word address; data refused in a locked zone.
// [R19] Array write into an unlocked zone acks data and continues normally.
// [R20] A selector matching none of the four is refused and does nothing.
// [R21] When frozen, a lock data byte is refused and all lock bits stay unchanged.
package rom_zone_pkg;

  localparam int ZONES                = 4;
  localparam int CLK_MHZ              = 250;
  // Self-timed write duration; plain default, the real figure is set per product
  localparam int WRITE_CYCLE_TIME_US  = 1000;
  localparam int WRITE_CYCLE_CYCLES   = WRITE_CYCLE_TIME_US * CLK_MHZ;

  localparam logic [3:0] OP_ZONE      = 4'h7;
  localparam logic [3:0] OP_FREEZE    = 4'h1;
  localparam logic [3:0] OP_ARRAY     = 4'ha;

  localparam int OP_MSB               = 7;
  localparam int OP_LSB               = 4;
  localparam int SLV_MSB              = 3;
  localparam int SLV_LSB              = 1;
  localparam int RW_BIT               = 0;
  localparam int ZONE_MSB             = 6;
  localparam int ZONE_LSB             = 5;

  localparam logic [3:0] SEL_ZONE0    = 4'h1;
  localparam logic [3:0] SEL_ZONE1    = 4'h2;
  localparam logic [3:0] SEL_ZONE2    = 4'h4;
  localparam logic [3:0] SEL_ZONE3    = 4'h8;

  localparam logic [7:0] LOCK_DATA    = 8'hff;
  localparam logic [7:0] FREEZE_KEY0  = 8'h55;
  localparam logic [7:0] FREEZE_KEY1  = 8'haa;
  localparam logic [7:0] STAT_OPEN    = 8'h00;
  localparam logic [7:0] STAT_LOCKED  = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE,
    ST_DEVADDR,
    ST_ZSEL,
    ST_ZDATA,
    ST_ZSTOP,
    ST_FKEY0,
    ST_FKEY1,
    ST_FSTOP,
    ST_AWORD,
    ST_ADATA,
    ST_IGNORE,
    ST_BUSY
  } fsm_e;

  // Byte-level events from the bit-frame engine
  typedef struct packed {
    logic       start;
    logic       stop;
    logic       valid;
    logic [7:0] data;
  } rx_s;

  // Answers back to the bit-frame engine
  typedef struct packed {
    logic       ack_valid;
    logic       ack;
    logic       rd_valid;
    logic [7:0] rd_data;
  } ans_s;

  // Programming request to the nonvolatile cells
  typedef struct packed {
    logic [ZONES-1:0] set_lock;
    logic             set_freeze;
  } nv_req_s;

endpackage

// ==== write_cycle_timer.sv ====
`timescale 1ns/1ns
module write_cycle_timer #(
  parameter int CYCLES = rom_zone_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic start_i,
  output logic      busy_o,
  output logic      done_o
);

  typedef struct packed {
    logic [31:0] cnt;
    logic        run;
    logic        done;
  } tmr_s;

  tmr_s r;
  tmr_s next_r;

  always_comb begin
    next_r      = r;
    next_r.done = 1'b0;
    if (start_i && !r.run) begin
      next_r.run = 1'b1;
      next_r.cnt = 32'(CYCLES - 1);
    end else if (r.run) begin
      if (r.cnt == 32'h0) begin
        next_r.run  = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - 32'h1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign busy_o = r.run;
  assign done_o = r.done;

endmodule

// ==== rom_zone_write_protect.sv ====
`timescale 1ns/1ns
module rom_zone_write_protect #(
  parameter logic [2:0] SLAVE_ADDR         = 3'h0,
  parameter int         WRITE_CYCLE_CYCLES = rom_zone_pkg::WRITE_CYCLE_CYCLES
) (
  input  wire logic                            clk_i,
  input  wire logic                            rst_n_i,
  input  wire rom_zone_pkg::rx_s               rx_i,
  input  wire logic [rom_zone_pkg::ZONES-1:0]  nv_lock_i,
  input  wire logic                            nv_frozen_i,
  output rom_zone_pkg::ans_s                   ans_o,
  output rom_zone_pkg::nv_req_s                nv_req_o,
  output logic                                 busy_o
);

  typedef struct packed {
    rom_zone_pkg::fsm_e                 st;
    logic [3:0]                         sel;
    logic [1:0]                         wzone;
    logic                               sel_ok;
    rom_zone_pkg::ans_s                 ans;
    rom_zone_pkg::nv_req_s              req;
    logic                               launch;
    logic                               busy;
  } ctl_s;

  ctl_s r;
  ctl_s next_r;
  logic tmr_done;

  // One-hot selector decode on the low nibble only
  function automatic logic sel_valid(input logic [7:0] b);
    logic [3:0] n;
    n = b[3:0];                                                      // see [R7]
    return (n == rom_zone_pkg::SEL_ZONE0) || (n == rom_zone_pkg::SEL_ZONE1) ||
           (n == rom_zone_pkg::SEL_ZONE2) || (n == rom_zone_pkg::SEL_ZONE3);
  endfunction

  // Lock state of the zone picked by a stored selector
  function automatic logic sel_locked(input logic [3:0] s, input logic [3:0] lk);
    return |(s & lk);                                                // see [R5]
  endfunction

  function automatic logic [7:0] status_byte(input logic locked);
    return locked ? rom_zone_pkg::STAT_LOCKED : rom_zone_pkg::STAT_OPEN;  // see [R8]
  endfunction

  write_cycle_timer #(
    .CYCLES (WRITE_CYCLE_CYCLES)
  ) u_timer (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .start_i (r.launch),
    .busy_o  (),
    .done_o  (tmr_done)
  );

  always_comb begin
    logic [3:0] op;
    logic       rw;
    logic       mine;
    op            = rx_i.data[rom_zone_pkg::OP_MSB:rom_zone_pkg::OP_LSB];
    rw            = rx_i.data[rom_zone_pkg::RW_BIT];
    mine          = rx_i.data[rom_zone_pkg::SLV_MSB:rom_zone_pkg::SLV_LSB] == SLAVE_ADDR;
    next_r        = r;
    next_r.ans    = '0;
    next_r.launch = 1'b0;

    if (r.st == rom_zone_pkg::ST_BUSY) begin
      // Everything on the line is ignored until the cell write ends
      if (tmr_done) begin                                            // see [R11]
        next_r.st  = rom_zone_pkg::ST_IDLE;
        next_r.req = '0;
      end
    end else if (rx_i.stop) begin
      case (r.st)
        rom_zone_pkg::ST_ZSTOP: begin
          next_r.st           = rom_zone_pkg::ST_BUSY;              // see [R10]
          next_r.req.set_lock = r.sel;                               // see [R4]
          next_r.launch       = 1'b1;
        end
        rom_zone_pkg::ST_FSTOP: begin
          next_r.st             = rom_zone_pkg::ST_BUSY;            // see [R15] [R17]
          next_r.req.set_freeze = 1'b1;
          next_r.launch         = 1'b1;
        end
        default: begin
          next_r.st = rom_zone_pkg::ST_IDLE;                         // see [R10] [R15]
        end
      endcase
      next_r.sel_ok = 1'b0;
    end else if (rx_i.start) begin
      // Repeated start keeps the selector for the status read
      next_r.st = rom_zone_pkg::ST_DEVADDR;
    end else if (rx_i.valid) begin
      case (r.st)
        rom_zone_pkg::ST_DEVADDR: begin
          next_r.st = rom_zone_pkg::ST_IGNORE;
          if (mine) begin
            case (op)
              rom_zone_pkg::OP_ZONE: begin
                if (!rw) begin
                  next_r.ans.ack_valid = 1'b1;                       // see [R8]
                  next_r.ans.ack       = 1'b1;
                  next_r.sel_ok        = 1'b0;
                  next_r.st            = rom_zone_pkg::ST_ZSEL;
                end else begin
                  next_r.ans.ack_valid = 1'b1;
                  next_r.ans.ack       = r.sel_ok;                   // see [R8]
                  next_r.ans.rd_valid  = r.sel_ok;
                  next_r.ans.rd_data   = status_byte(sel_locked(r.sel, nv_lock_i));  // see [R2] [R3]
                end
              end
              rom_zone_pkg::OP_FREEZE: begin
                if (!rw) begin
                  next_r.ans.ack_valid = 1'b1;
                  next_r.ans.ack       = !nv_frozen_i;               // see [R13]
                  if (!nv_frozen_i) begin
                    next_r.st = rom_zone_pkg::ST_FKEY0;
                  end
                end
              end
              rom_zone_pkg::OP_ARRAY: begin
                if (!rw) begin
                  next_r.ans.ack_valid = 1'b1;                       // see [R18]
                  next_r.ans.ack       = 1'b1;
                  next_r.st            = rom_zone_pkg::ST_AWORD;
                end
              end
              default: begin
                next_r.st = rom_zone_pkg::ST_IGNORE;
              end
            endcase
          end
        end
        rom_zone_pkg::ST_ZSEL: begin
          next_r.ans.ack_valid = 1'b1;
          if (sel_valid(rx_i.data)) begin
            next_r.ans.ack = 1'b1;
            next_r.sel     = rx_i.data[3:0];                         // see [R7]
            next_r.sel_ok  = 1'b1;
            next_r.st      = rom_zone_pkg::ST_ZDATA;
          end else begin
            next_r.ans.ack = 1'b0;                                   // see [R20]
            next_r.st      = rom_zone_pkg::ST_IGNORE;
          end
        end
        rom_zone_pkg::ST_ZDATA: begin
          next_r.ans.ack_valid = 1'b1;
          next_r.sel_ok        = 1'b0;
          if (rx_i.data == rom_zone_pkg::LOCK_DATA && !nv_frozen_i) begin
            next_r.ans.ack = 1'b1;                                   // see [R9]
            next_r.st      = rom_zone_pkg::ST_ZSTOP;
          end else begin
            next_r.ans.ack = 1'b0;                                   // see [R16] [R21]
            next_r.st      = rom_zone_pkg::ST_IGNORE;
          end
        end
        rom_zone_pkg::ST_FKEY0: begin
          next_r.ans.ack_valid = 1'b1;
          next_r.ans.ack       = rx_i.data == rom_zone_pkg::FREEZE_KEY0;  // see [R14]
          next_r.st            = (rx_i.data == rom_zone_pkg::FREEZE_KEY0) ?
                                 rom_zone_pkg::ST_FKEY1 : rom_zone_pkg::ST_IGNORE;
        end
        rom_zone_pkg::ST_FKEY1: begin
          next_r.ans.ack_valid = 1'b1;
          next_r.ans.ack       = rx_i.data == rom_zone_pkg::FREEZE_KEY1;  // see [R14]
          next_r.st            = (rx_i.data == rom_zone_pkg::FREEZE_KEY1) ?
                                 rom_zone_pkg::ST_FSTOP : rom_zone_pkg::ST_IGNORE;
        end
        rom_zone_pkg::ST_AWORD: begin
          next_r.ans.ack_valid = 1'b1;                               // see [R18]
          next_r.ans.ack       = 1'b1;
          next_r.wzone         = rx_i.data[rom_zone_pkg::ZONE_MSB:rom_zone_pkg::ZONE_LSB];  // see [R1] [R5]
          next_r.st            = rom_zone_pkg::ST_ADATA;
        end
        rom_zone_pkg::ST_ADATA: begin
          next_r.ans.ack_valid = 1'b1;
          if (nv_lock_i[r.wzone]) begin
            next_r.ans.ack = 1'b0;                                   // see [R18] [R3]
            next_r.st      = rom_zone_pkg::ST_IDLE;
          end else begin
            next_r.ans.ack = 1'b1;                                   // see [R19]
            next_r.st      = rom_zone_pkg::ST_ADATA;
          end
        end
        rom_zone_pkg::ST_ZSTOP, rom_zone_pkg::ST_FSTOP: begin
          // Extra byte where only a stop belongs
          next_r.ans.ack_valid = 1'b1;
          next_r.ans.ack       = 1'b0;
          next_r.st            = rom_zone_pkg::ST_IGNORE;
        end
        default: begin
          next_r.st = r.st;
        end
      endcase
    end
    next_r.busy = next_r.st == rom_zone_pkg::ST_BUSY;                // see [R11]
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign ans_o    = r.ans;
  assign nv_req_o = r.req;
  assign busy_o   = r.busy;

endmodule

// ==== rom_zone_write_protect_sva.sv ====
`timescale 1ns/1ns
module rom_zone_write_protect_sva #(
  parameter logic [2:0] SLAVE_ADDR         = 3'h0,
  parameter int         WRITE_CYCLE_CYCLES = rom_zone_pkg::WRITE_CYCLE_CYCLES
) (
  input wire logic                           clk_i,
  input wire logic                           rst_n_i,
  input wire rom_zone_pkg::rx_s              rx_i,
  input wire logic [rom_zone_pkg::ZONES-1:0] nv_lock_i,
  input wire logic                           nv_frozen_i,
  input wire rom_zone_pkg::ans_s             ans_o,
  input wire rom_zone_pkg::nv_req_s          nv_req_o,
  input wire logic                           busy_o
);
  localparam int         BUSY_MIN = WRITE_CYCLE_CYCLES;
  localparam int         BUSY_MAX = WRITE_CYCLE_CYCLES + 2;
  localparam logic [7:0] FRZ_ADDR = {rom_zone_pkg::OP_FREEZE, SLAVE_ADDR, 1'b0};
  int   busy_len;
  logic first_byte;
  // Cycles spent in the running write cycle; long cycles need a counter, not a delay range
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_len <= 0;
    end else if (busy_o) begin
      busy_len <= busy_len + 1;
    end else begin
      busy_len <= 0;
    end
  end
  // High while the next byte taken is the address byte of a sequence
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_byte <= 1'b0;
    end else if (!busy_o) begin
      if (rx_i.stop) begin
        first_byte <= 1'b0;
      end else if (rx_i.start) begin
        first_byte <= 1'b1;
      end else if (rx_i.valid) begin
        first_byte <= 1'b0;
      end
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  busy_quiet_a: assert property (busy_o |=> !ans_o.ack_valid && !ans_o.rd_valid)
    else $error("answer given during write cycle");
  write_len_a: assert property ($fell(busy_o) |-> busy_len >= BUSY_MIN && busy_len <= BUSY_MAX)
    else $error("write cycle length wrong");
  one_request_a: assert property (busy_o |-> $onehot({nv_req_o.set_lock, nv_req_o.set_freeze}))
    else $error("write request not one-hot");
  idle_request_a: assert property (!busy_o |-> nv_req_o == '0)
    else $error("write request outside write cycle");
  stop_start_a: assert property ($rose(busy_o) |-> $past(rx_i.stop))
    else $error("write cycle began without stop");
  frozen_hold_a: assert property (nv_frozen_i |-> !$rose(busy_o))
    else $error("write started while frozen");
  freeze_ack_a: assert property (first_byte && !busy_o && !rx_i.stop && !rx_i.start && rx_i.valid
    && rx_i.data == FRZ_ADDR |=> ans_o.ack_valid && ans_o.ack == !$past(nv_frozen_i))
    else $error("freeze address answer wrong");
  status_data_a: assert property (ans_o.rd_valid |-> ans_o.ack_valid && ans_o.ack
    && (ans_o.rd_data == 8'hff || ans_o.rd_data == 8'h00) && (nv_lock_i != '0 || ans_o.rd_data == 8'h00))
    else $error("status byte wrong");
  ack_cause_a: assert property (ans_o.ack_valid |-> $past(rx_i.valid) && !$past(busy_o))
    else $error("answer without a byte");
endmodule

bind rom_zone_write_protect rom_zone_write_protect_sva #(
  .SLAVE_ADDR(SLAVE_ADDR), .WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)
) u_rom_zone_write_protect_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .rx_i(rx_i), .nv_lock_i(nv_lock_i),
  .nv_frozen_i(nv_frozen_i), .ans_o(ans_o), .nv_req_o(nv_req_o), .busy_o(busy_o));

// ==== nv_cell_model.sv ====
`timescale 1ns/1ns
module nv_cell_model (
  input  wire logic                      clk_i,
  input  wire rom_zone_pkg::nv_req_s     req_i,
  output logic [rom_zone_pkg::ZONES-1:0] lock_o,
  output logic                           frozen_o
);
  rom_zone_pkg::nv_req_s prev;
  // Delivered erased; reset never touches the cells
  initial begin
    lock_o = '0;
    frozen_o = 1'b0;
    prev = '0;
  end
  // Bits only gain ones, committed when the write cycle ends
  always @(posedge clk_i) begin
    prev <= req_i;
    if (req_i == '0) begin
      lock_o <= lock_o | prev.set_lock;
      frozen_o <= frozen_o | prev.set_freeze;
    end
  end
endmodule

// ==== rom_zone_write_protect_tb_top.sv ====
`timescale 1ns/1ns
module rom_zone_write_protect_tb_top;
  localparam int          WCC = 20;
  localparam logic [2:0]  S = 3'b100, P = 3'b010, V = 3'b001;
  localparam logic [10:0] AK = 11'h500, NK = 11'h400, R0 = 11'h700, RF = 11'h7ff;
  logic                  clk_i = 1'b0;
  logic                  rst_n_i = 1'b0;
  rom_zone_pkg::rx_s     rx = '0;
  rom_zone_pkg::ans_s    ans;
  rom_zone_pkg::nv_req_s req;
  logic [3:0]            lock;
  logic                  frozen;
  logic                  busy;
  logic [10:0]           expq[$];
  logic [7:0]            r;
  int                    fails = 0;
  int                    n_compared = 0;
  initial forever #2 clk_i = ~clk_i;
  rom_zone_write_protect #(.WRITE_CYCLE_CYCLES(WCC)) u_rom_zone_write_protect (.clk_i(clk_i),
    .rst_n_i(rst_n_i), .rx_i(rx), .nv_lock_i(lock), .nv_frozen_i(frozen), .ans_o(ans), .nv_req_o(req),
    .busy_o(busy));
  nv_cell_model u_nv_cell_model (.clk_i(clk_i), .req_i(req), .lock_o(lock), .frozen_o(frozen));
  task automatic chk_ans(string what, logic [10:0] exp, logic [10:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_st(string what, logic [5:0] exp, logic [5:0] got);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic report_and_stop();
    chk_st("pending answers", 6'h00, 6'(expq.size()));
    if (fails == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One event per call, then an idle cycle; answers are noted for the monitor
  task automatic put(logic [2:0] spv, logic [7:0] d, logic [10:0] e = 11'h000);
    @(negedge clk_i);
    rx <= rom_zone_pkg::rx_s'({spv, d});
    if (e[10]) expq.push_back(e);
    @(negedge clk_i);
    rx <= '0;
  endtask
  task automatic query(logic [7:0] sel, logic [10:0] e);
    put(S, 8'h00); put(V, 8'h70, AK); put(V, sel, AK); put(S, 8'h00); put(V, 8'h71, e); put(P, 8'h00);
  endtask
  task automatic lock_zone(logic [7:0] sel, logic [7:0] d, logic [10:0] e);
    put(S, 8'h00); put(V, 8'h70, AK); put(V, sel, AK); put(V, d, e); put(P, 8'h00);
  endtask
  task automatic wait_idle();
    int i;
    i = 0;
    while (busy !== 1'b0 && i < 100) begin
      @(negedge clk_i);
      i++;
    end
    @(negedge clk_i);
    if (i == 100) begin
      fails++;
      report_and_stop();
    end
  endtask
  // Answers are looked at mid-cycle, where they stand settled
  always @(negedge clk_i) begin
    if (ans.ack_valid === 1'b1 || ans.rd_valid === 1'b1) begin
      if (expq.size() == 0) chk_ans("unexpected answer", 11'h000, {ans.ack_valid, ans.rd_valid, ans.ack, ans.rd_data});
      else chk_ans("answer", expq.pop_front(), {ans.ack_valid, ans.rd_valid, ans.ack, ans.rd_data});
    end
  end
  initial begin
    void'($urandom(10));
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    for (int z = 0; z < 4; z++) begin
      r = $urandom();
      query({r[7:4], 4'h1 << z}, R0);
    end
    put(S, 8'h00); put(V, 8'h70, AK); put(V, 8'h03, NK); put(V, 8'hff); put(P, 8'h00);
    put(S, 8'h00); put(V, 8'h71, NK); put(P, 8'h00);
    r = $urandom();
    put(S, 8'h00); put(V, {4'h7, r[3:1] | 3'h1, 1'b0}); put(V, 8'h02); put(P, 8'h00);
    r = $urandom();
    put(S, 8'h00); put(V, 8'ha0, AK); put(V, {3'h1, r[4:0]}, AK); put(V, r, AK); put(V, r, AK);
    put(P, 8'h00);
    r = $urandom();
    lock_zone({r[7:4], 4'h2}, 8'hff, AK);
    chk_st("write start", 6'h20, {busy, frozen, lock});
    put(V, 8'h70);
    wait_idle();
    chk_st("zone locked", 6'h02, {busy, frozen, lock});
    put(S, 8'h00); put(V, 8'h70, AK); put(V, 8'h04, AK); put(P, 8'h00);
    put(S, 8'h00); put(V, 8'h70, AK); put(V, 8'h04, AK); put(V, 8'hff, AK);
    put(V, 8'h00, NK); put(P, 8'h00);
    lock_zone(8'h04, 8'h7f, NK);
    chk_st("aborted lock", 6'h02, {busy, frozen, lock});
    query(8'h02, RF);
    put(S, 8'h00); put(V, 8'ha0, AK); put(V, {3'h1, r[4:0]}, AK); put(V, r, NK);
    query(8'h04, R0);
    put(S, 8'h00); put(V, 8'h10, AK); put(V, 8'h56, NK); put(P, 8'h00);
    put(S, 8'h00); put(V, 8'h10, AK); put(V, 8'h55, AK); put(V, 8'hab, NK); put(P, 8'h00);
    put(S, 8'h00); put(V, 8'h10, AK); put(V, 8'h55, AK); put(P, 8'h00);
    chk_st("freeze refused", 6'h02, {busy, frozen, lock});
    put(S, 8'h00); put(V, 8'h10, AK); put(V, 8'h55, AK); put(V, 8'haa, AK); put(P, 8'h00);
    chk_st("freeze start", 6'h22, {busy, frozen, lock});
    wait_idle();
    chk_st("frozen", 6'h12, {busy, frozen, lock});
    put(S, 8'h00); put(V, 8'h10, NK); put(P, 8'h00);
    lock_zone(8'h08, 8'hff, NK);
    chk_st("frozen locks", 6'h12, {busy, frozen, lock});
    @(negedge clk_i);
    rst_n_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk_st("after reset", 6'h12, {busy, frozen, lock});
    query(8'h02, RF);
    query(8'h08, R0);
    report_and_stop();
  end
endmodule
